/* rtl/byte_link_gpio_port.sv */
// Purpose: general-purpose port sharing pins with the byte link controller
// Assumes: AXI4-Lite slave on sys_clk_i, one write and one read at a time
// Notes:   link controller supplies its own pin drive and ownership mask
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.

`default_nettype none

module byte_link_gpio_port (
  input  wire logic                                sys_clk_i,
  input  wire logic                                nrst_i,
  // axi4-lite write address
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] s_axi_awaddr_i,
  input  wire logic                                s_axi_awvalid_i,
  output logic                                     s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                          s_axi_wstrb_i,
  input  wire logic                                s_axi_wvalid_i,
  output logic                                     s_axi_wready_o,
  // axi4-lite write response
  output logic      [1:0]                          s_axi_bresp_o,
  output logic                                     s_axi_bvalid_o,
  input  wire logic                                s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] s_axi_araddr_i,
  input  wire logic                                s_axi_arvalid_i,
  output logic                                     s_axi_arready_o,
  // axi4-lite read data
  output logic      [gpio_port_pkg::DATA_WIDTH-1:0] s_axi_rdata_o,
  output logic      [1:0]                          s_axi_rresp_o,
  output logic                                     s_axi_rvalid_o,
  input  wire logic                                s_axi_rready_i,
  // port pins, split into input, output and enable
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0]  pin_i,
  output logic      [gpio_port_pkg::PIN_COUNT-1:0]  pin_o,
  output logic      [gpio_port_pkg::PIN_COUNT-1:0]  pin_oe_o,
  output logic                                     pin_pullup_en_o,
  // link controller side
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0]  link_pin_out_i,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0]  link_pin_own_i,
  output logic                                     link_function_enable_o
);
  import gpio_port_pkg::*;

  // ==========================================================
  // registers
  logic [PIN_COUNT-1:0] port_data_reg;  // output latch
  logic [PIN_COUNT-1:0] port_dir_reg;   // pin direction bits
  logic                 link_en_reg;    // link function enable
  logic                 pullup_reg;     // pullup enable
  logic [PIN_COUNT-1:0] pin_level_sync; // synchronised pin level
  logic [PIN_COUNT-1:0] link_owned;     // pins held by the link

  // write channel holding
  logic                  aw_held_reg;   // address taken, awaiting data
  logic [ADDR_WIDTH-1:0] aw_addr_reg;   // taken write address
  logic                  w_held_reg;    // data taken, awaiting address
  logic [DATA_WIDTH-1:0] w_data_reg;    // taken write data
  logic [3:0]            w_strb_reg;    // taken byte strobes
  logic                  wr_fire;       // both halves present
  logic [ADDR_WIDTH-1:0] wr_addr;       // effective write address
  logic [DATA_WIDTH-1:0] wr_data;       // effective write data
  logic [3:0]            wr_strb;       // effective strobes
  logic                  wr_lane0;      // low byte lane written

  // ==========================================================
  // pin synchroniser
  pin_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (pin_i),
    .sync_o    (pin_level_sync)
  );

  // ==========================================================
  // pin ownership and drive
  // link owns a pin only while its function is enabled
  assign link_owned = link_en_reg ? link_pin_own_i : '0;

  // per-pin drive selection
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pin_o[g]    <= 1'b0;
          pin_oe_o[g] <= 1'b0;
        end else if (link_owned[g]) begin
          // link drives its own pin, latch ignored
          pin_o[g]    <= link_pin_out_i[g];
          pin_oe_o[g] <= 1'b1;
        end else begin
          // latch drives only when direction is output
          pin_o[g]    <= port_data_reg[g];
          pin_oe_o[g] <= port_dir_reg[g];
        end
      end
    end
  endgenerate

  // pullup enable straight from its register bit
  assign pin_pullup_en_o        = pullup_reg;
  assign link_function_enable_o = link_en_reg;

  // ==========================================================
  // axi write path
  // ready while the half is not yet held and no response pending
  assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;

  // merge held and live halves
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr_i;
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata_i;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb_i;
  assign wr_fire = (aw_held_reg || (s_axi_awvalid_i && s_axi_awready_o))
                && (w_held_reg || (s_axi_wvalid_i && s_axi_wready_o));
  assign wr_lane0 = wr_fire && wr_strb[0];

  // hold whichever half arrives first
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
    end
  end

  // write response, error for unmapped address
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      unique case (wr_addr)
        OFFS_PORT_DATA, OFFS_PORT_DIR, OFFS_PORT_CTRL: begin
          s_axi_bresp_o <= RESP_OKAY;
        end
        default: begin
          s_axi_bresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // register writes, taken on any write with the low byte strobe set
  // output latch, written even when the link owns the pin
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_data_reg <= PORT_DATA_RST;
    end else if (wr_lane0 && wr_addr == OFFS_PORT_DATA) begin
      port_data_reg <= wr_data[PIN_COUNT-1:0];
    end
  end

  // direction bits, reset to all inputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_dir_reg <= PORT_DIR_RST;
    end else if (wr_lane0 && wr_addr == OFFS_PORT_DIR) begin
      port_dir_reg <= wr_data[PIN_COUNT-1:0];
    end
  end

  // control bits
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_en_reg <= LINK_EN_RST;
      pullup_reg  <= PULLUP_RST;
    end else if (wr_lane0 && wr_addr == OFFS_PORT_CTRL) begin
      link_en_reg <= wr_data[CTRL_LINK_EN_BIT];
      pullup_reg  <= wr_data[CTRL_PULLUP_BIT];
    end
  end

  // ==========================================================
  // axi read path
  // one read at a time, address taken only when idle
  assign s_axi_arready_o = !s_axi_rvalid_o;

  // read data registered one cycle after the address
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= RESP_OKAY;
      unique case (s_axi_araddr_i)
        OFFS_PORT_DATA: begin
          // per pin: latch for outputs, pin level for inputs
          s_axi_rdata_o[PIN_COUNT-1:0] <=
            (port_dir_reg & port_data_reg)
            | (~port_dir_reg & pin_level_sync);
        end
        OFFS_PORT_DIR: begin
          s_axi_rdata_o[PIN_COUNT-1:0] <= port_dir_reg;
        end
        OFFS_PORT_CTRL: begin
          s_axi_rdata_o[CTRL_LINK_EN_BIT] <= link_en_reg;
          s_axi_rdata_o[CTRL_PULLUP_BIT]  <= pullup_reg;
        end
        default: begin
          s_axi_rresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* rtl/gpio_port_pkg.sv */
// Purpose: shared constants for the byte link general-purpose port
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   register offsets are byte addresses

`default_nettype none

package gpio_port_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PIN_COUNT  = 7;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned REG_WIDTH  = 8;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_WIDTH-1:0] OFFS_PORT_DATA = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] OFFS_PORT_DIR  = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] OFFS_PORT_CTRL = 4'h8;

  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_LINK_EN_BIT = 0;
  localparam int unsigned CTRL_PULLUP_BIT  = 1;

  // ==========================================================
  // reset values
  localparam logic [PIN_COUNT-1:0] PORT_DATA_RST = 7'h00;
  localparam logic [PIN_COUNT-1:0] PORT_DIR_RST  = 7'h00;
  localparam logic                 LINK_EN_RST   = 1'b0;
  localparam logic                 PULLUP_RST    = 1'b0;

  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* rtl/pin_sync.sv */
// Purpose: two flip-flop synchroniser for the port pin inputs
// Assumes: pins are asynchronous to sys_clk_i
// Notes:   first stage is read only by the second stage

`default_nettype none

module pin_sync (
  input  wire logic                               sys_clk_i,
  input  wire logic                               nrst_i,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] async_i,
  output logic      [gpio_port_pkg::PIN_COUNT-1:0] sync_o
);
  import gpio_port_pkg::*;

  // ==========================================================
  // synchroniser stages
  logic [PIN_COUNT-1:0] meta_reg; // first stage, metastable capture

  // two-stage capture per pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_reg[g] <= 1'b0;
          sync_o[g]   <= 1'b0;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_o[g]   <= meta_reg[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* verification/byte_link_gpio_port_props.sv */
// Purpose: port-level checks for the byte link general-purpose port
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound onto every instance of the port
`default_nettype none
module byte_link_gpio_port_props (
  input wire logic                                 sys_clk_i,
  input wire logic                                 nrst_i,
  input wire logic                                 s_axi_awvalid_i,
  input wire logic                                 s_axi_awready_o,
  input wire logic                                 s_axi_wvalid_i,
  input wire logic                                 s_axi_wready_o,
  input wire logic [1:0]                           s_axi_bresp_o,
  input wire logic                                 s_axi_bvalid_o,
  input wire logic                                 s_axi_bready_i,
  input wire logic                                 s_axi_arvalid_i,
  input wire logic                                 s_axi_arready_o,
  input wire logic [gpio_port_pkg::DATA_WIDTH-1:0] s_axi_rdata_o,
  input wire logic                                 s_axi_rvalid_o,
  input wire logic                                 s_axi_rready_i,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0]  pin_o,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0]  pin_oe_o,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0]  link_pin_out_i,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0]  link_pin_own_i,
  input wire logic                                 link_function_enable_o
);
  import gpio_port_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // pins
  reset_idle_a: assert property ($rose(nrst_i) |-> pin_oe_o == '0)
    else $error("pin driven right after reset");
  link_drive_a: assert property (link_function_enable_o |=>
    (pin_oe_o & $past(link_pin_own_i)) == $past(link_pin_own_i))
    else $error("link-owned pin not driven");
  link_value_a: assert property (link_function_enable_o |=>
    ((pin_o ^ $past(link_pin_out_i)) & $past(link_pin_own_i)) == '0)
    else $error("link-owned pin lost its link value");
  // ==========================================================
  // register bus
  write_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o
    && s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  read_upper_a: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:7] == '0 && !s_axi_arready_o)
    else $error("read upper bits or gate wrong");
  busy_refuse_a: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while answering");
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && !s_axi_rready_i);
  cover property (link_function_enable_o && link_pin_own_i != '0);
endmodule
bind byte_link_gpio_port byte_link_gpio_port_props props_i (.sys_clk_i,
  .nrst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .pin_o, .pin_oe_o, .link_pin_out_i, .link_pin_own_i,
  .link_function_enable_o);
`default_nettype wire

/* verification/pin_board.sv */
// Purpose: board circuitry on the port pins
// Assumes: device drive wins over the board driver
// Notes:   a floating pin without pullup toggles every cycle
`default_nettype none
module pin_board (
  input  wire logic                                sys_clk_i,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_o,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_oe_o,
  input  wire logic                                pin_pullup_en_o,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] ext_val_i,
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] ext_en_i,
  output logic      [gpio_port_pkg::PIN_COUNT-1:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_pkg::*;
  logic [PIN_COUNT-1:0] float_reg = 7'h2a; // never settles when undriven
  always @(posedge sys_clk_i) float_reg <= ~float_reg;
  // device, then board driver, then pullup, then floating noise
  assign level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
    | (~pin_oe_o & ~ext_en_i & (pin_pullup_en_o ? '1 : float_reg));
endmodule
`default_nettype wire

/* verification/byte_link_gpio_port_bench.sv */
// Purpose: self-checking bench for the byte link port
// Assumes: AXI4-Lite master tasks, board model on the pins
// Notes:   pin reads wait for the two-flop synchroniser
`default_nettype none
module byte_link_gpio_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_pkg::*;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0;
  logic [ADDR_WIDTH-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [DATA_WIDTH-1:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = '0;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [PIN_COUNT-1:0] pin_i, pin_o, pin_oe_o, ext_val = '0, ext_en = '0;
  logic [PIN_COUNT-1:0] link_pin_out_i = '0, link_pin_own_i = '0;
  logic pin_pullup_en_o, link_function_enable_o;
  int errors = 0, comparisons = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  byte_link_gpio_port DUT (.sys_clk_i, .nrst_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .pin_i, .pin_o, .pin_oe_o, .pin_pullup_en_o, .link_pin_out_i,
    .link_pin_own_i, .link_function_enable_o);
  pin_board board (.sys_clk_i, .pin_o, .pin_oe_o, .pin_pullup_en_o,
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));
  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write; bready rises only once the answer shows, to stall it
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      n++;
      if ((s_axi_bvalid_o && s_axi_bready_i) || n >= 50) break;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) s_axi_bready_i <= 1'b1;
    end
    if (n >= 50) begin
      errors++;
      stop_test();
    end
    chk("bresp", 32'(er), 32'(s_axi_bresp_o));
    s_axi_bready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // read; data compared only on an okay answer
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      n++;
      if ((s_axi_rvalid_o && s_axi_rready_i) || n >= 50) break;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) s_axi_rready_i <= 1'b1;
    end
    if (n >= 50) begin
      errors++;
      stop_test();
    end
    chk("rresp", 32'(er), 32'(s_axi_rresp_o));
    if (er == RESP_OKAY) chk("rdata", e, s_axi_rdata_o);
    s_axi_rready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    settle();
    chk("oe", 0, pin_oe_o);
    chk("pullup", 0, pin_pullup_en_o);
    chk("link", 0, link_function_enable_o);
    rd(OFFS_PORT_DIR, 0, RESP_OKAY);
    rd(OFFS_PORT_CTRL, 0, RESP_OKAY);
    ext_en <= 7'h7f;
    ext_val <= 7'h55;
    wr(OFFS_PORT_DIR, 32'h0f, 4'hf, RESP_OKAY);
    wr(OFFS_PORT_DATA, 32'h3c, 4'hf, RESP_OKAY);
    settle();
    chk("oe", 32'h0f, pin_oe_o);
    chk("drive", 32'h0c, pin_o & 7'h0f);
    rd(OFFS_PORT_DATA, 32'h5c, RESP_OKAY);
    rd(OFFS_PORT_DIR, 32'h0f, RESP_OKAY);
    wr(OFFS_PORT_DATA, 32'h00, 4'h0, RESP_OKAY);
    rd(OFFS_PORT_DATA, 32'h5c, RESP_OKAY);
    wr(4'hc, 32'h01, 4'hf, RESP_SLVERR);
    rd(4'hc, 0, RESP_SLVERR);
    link_pin_own_i <= 7'h03;
    link_pin_out_i <= 7'h01;
    wr(OFFS_PORT_CTRL, 32'h01, 4'hf, RESP_OKAY);
    wr(OFFS_PORT_DATA, 32'h7e, 4'hf, RESP_OKAY);
    settle();
    chk("link", 1, link_function_enable_o);
    chk("drive", 32'h0d, pin_o & 7'h0f);
    chk("oe", 32'h0f, pin_oe_o);
    rd(OFFS_PORT_DATA, 32'h5e, RESP_OKAY);
    wr(OFFS_PORT_CTRL, 32'h00, 4'hf, RESP_OKAY);
    settle();
    chk("drive", 32'h0e, pin_o & 7'h0f);
    ext_en <= 7'h00;
    wr(OFFS_PORT_DIR, 32'h00, 4'hf, RESP_OKAY);
    wr(OFFS_PORT_CTRL, 32'h02, 4'hf, RESP_OKAY);
    settle();
    chk("pullup", 1, pin_pullup_en_o);
    chk("oe", 0, pin_oe_o);
    rd(OFFS_PORT_DATA, 32'h7f, RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
